// *** design/lmm_top.sv ***
// life and maintenance monitor: capacitor measurement, fan, hours timer
// assumes pin inputs are asynchronous; register port is synchronous
`timescale 1ns/100ps
`include "lmm_regs.svh"
module lmm_top
  import lmm_pkg::*;
#(
  parameter int N_FAN = 2,
  parameter int N_TERM = 7,
  parameter logic [39:0] HOUR_CYCLES = 40'(`LMM_HOUR_CYCLES),
  parameter logic [31:0] STIM_CYCLES = 32'(`LMM_STIM_CYCLES)
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic supply_ok_i, // pin: mains present
  input wire logic motor_present_i, // pin
  input wire logic motor_coasting_i, // pin
  input wire logic output_shutoff_input_i, // pin
  input wire logic start_cmd_i, // pin
  input wire logic alarm_stop_i, // pin
  input wire logic meas_error_i, // pin: front end saw a bad measurement
  input wire logic [7:0] cap_meas_pct_i, // front-end result, stable at stimulus end
  input wire logic [N_FAN-1:0] fan_slow_i, // pins: fan at or below half speed
  input wire logic ctrl_cap_life_i, // pin: control capacitor worn
  input wire logic inrush_life_i, // pin: inrush circuit worn
  output logic dc_stim_o, // motor stimulus enable
  output logic fan_fault_indication_o,
  output logic maint_due_indication_o,
  output logic life_alarm_out_o,
  output logic maint_timer_alarm_out_o,
  output logic [N_TERM-1:0] terminal_o,
  output logic nv_save_o, // one-cycle pulse per completed hour
  output logic [15:0] nv_hours_o, // timer value to store
  output logic [6:0] nv_sub_o, // hours into the current 100h unit
  output logic irq_o
);
  localparam int NS = 7 + N_FAN; // synchronised pin count

  // ********************************
  // pin synchronisers
  // ********************************
  logic [NS-1:0] sync1_r; // first stage, read only by sync2_r
  logic [NS-1:0] sync2_r;
  logic pw_ok, mot_ok, coast, shutoff, start, alm_stop, m_err;
  logic fan_any;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {fan_slow_i, meas_error_i, alarm_stop_i, start_cmd_i,
                  output_shutoff_input_i, motor_coasting_i, motor_present_i,
                  supply_ok_i};
      sync2_r <= sync1_r;
    end
  end

  assign pw_ok = sync2_r[0];
  assign mot_ok = sync2_r[1];
  assign coast = sync2_r[2];
  assign shutoff = sync2_r[3];
  assign start = sync2_r[4];
  assign alm_stop = sync2_r[5];
  assign m_err = sync2_r[6];
  assign fan_any = |sync2_r[NS-1:7]; // one slow fan is enough

  // separate sync for the two external life flags
  logic [1:0] ext1_r; // first stage only
  logic [1:0] ext2_r;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext1_r <= '0;
      ext2_r <= '0;
    end else begin
      ext1_r <= {inrush_life_i, ctrl_cap_life_i};
      ext2_r <= ext1_r;
    end
  end

  // ********************************
  // register strobes
  // ********************************
  logic wr_state, wr_timer, wr_thresh, wr_mask, rd_irq;
  assign wr_state = reg_wr_i && reg_addr_i == `LMM_OFS_MEAS_STATE;
  assign wr_timer = reg_wr_i && reg_addr_i == `LMM_OFS_HOURS_TIMER;
  assign wr_thresh = reg_wr_i && reg_addr_i == `LMM_OFS_ALARM_THRESH;
  assign wr_mask = reg_wr_i && reg_addr_i == `LMM_OFS_IRQ_MASK;
  assign rd_irq = reg_rd_i && reg_addr_i == `LMM_OFS_IRQ_STATUS;

  // ********************************
  // capacitor measurement sequencer
  // ********************************
  lmm_meas_t st_r, st_nxt;
  logic [31:0] stim_cnt_r, stim_cnt_nxt; // stimulus cycles elapsed
  logic [7:0] pct_r, pct_nxt; // main_cap_life_percent
  logic cap_worn_r, cap_worn_nxt;
  logic meas_end; // sequence leaves the measuring state at the next edge

  always_comb begin
    st_nxt = st_r;
    stim_cnt_nxt = stim_cnt_r;
    pct_nxt = pct_r;
    cap_worn_nxt = cap_worn_r;
    unique case (st_r)
      LMM_S_MEAS: begin
        stim_cnt_nxt = stim_cnt_r + 32'h1;
        if (pw_ok || shutoff || start) begin
          st_nxt = LMM_S_FORCED; // power back, shut off or start
        end else if (alm_stop || !mot_ok || coast || m_err) begin
          st_nxt = LMM_S_ERROR; // fault or no usable motor
        end else if (stim_cnt_r == STIM_CYCLES - 32'h1) begin
          st_nxt = LMM_S_DONE; // stimulus held for 1s
          pct_nxt = cap_meas_pct_i; // shipment value is 100
          cap_worn_nxt = cap_meas_pct_i <= `LMM_CAP_LIMIT;
        end
      end
      LMM_S_ARMED: begin
        if (wr_state && reg_wdata_i[3:0] == `LMM_ST_IDLE) begin
          st_nxt = LMM_S_IDLE;
        end else if (!pw_ok) begin
          stim_cnt_nxt = '0;
          if (alm_stop || shutoff) begin
            st_nxt = LMM_S_ARMED; // never started, stays armed
          end else if (!mot_ok || coast) begin
            st_nxt = LMM_S_ERROR;
          end else begin
            st_nxt = LMM_S_MEAS; // power removed while armed
          end
        end
      end
      default: begin
        // idle and finished states accept only 0 or 1
        if (wr_state && reg_wdata_i[3:0] == `LMM_ST_ARMED) begin
          st_nxt = LMM_S_ARMED;
        end else if (wr_state && reg_wdata_i[3:0] == `LMM_ST_IDLE) begin
          st_nxt = LMM_S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= LMM_S_IDLE;
      stim_cnt_r <= '0;
      pct_r <= `LMM_CAP_FULL;
      cap_worn_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      stim_cnt_r <= stim_cnt_nxt;
      pct_r <= pct_nxt;
      cap_worn_r <= cap_worn_nxt;
    end
  end

  assign meas_end = st_r == LMM_S_MEAS && st_nxt != LMM_S_MEAS;
  assign dc_stim_o = st_r == LMM_S_MEAS; // stimulus only while measuring

  // state field as reported codes
  function automatic logic [3:0] state_code(input lmm_meas_t s);
    unique case (s)
      LMM_S_IDLE: state_code = `LMM_ST_IDLE;
      LMM_S_ARMED: state_code = `LMM_ST_ARMED;
      LMM_S_MEAS: state_code = `LMM_ST_MEAS;
      LMM_S_DONE: state_code = `LMM_ST_DONE;
      LMM_S_FORCED: state_code = `LMM_ST_FORCED;
      LMM_S_ERROR: state_code = `LMM_ST_ERROR;
      default: state_code = `LMM_ST_ERROR; // broken one-hot code reads as error
    endcase
  endfunction : state_code

  // ********************************
  // life status word
  // ********************************
  logic [3:0] life_word;
  logic fan_r, fan_nxt;
  assign fan_nxt = fan_any;
  assign life_word = {ext2_r[1], fan_r, cap_worn_r, ext2_r[0]};
  assign fan_fault_indication_o = fan_r;
  assign life_alarm_out_o = |life_word; // any life bit raises the alarm

  // ********************************
  // energized hours timer
  // ********************************
  logic hour_tick;
  logic [15:0] tmr_r, tmr_nxt; // energized_hours_timer, 100h units
  logic [6:0] sub_r, sub_nxt; // whole hours into current unit
  logic [15:0] thr_r, thr_nxt; // maint_alarm_threshold
  logic maint_al;
  logic [8*N_TERM-1:0] term_codes, term_codes_nxt; // terminal function codes, 8 bits each

  lmm_hour_prescaler #(
    .HOUR_CYCLES(HOUR_CYCLES)
  ) u_hour (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .run_i(pw_ok),
    .tick_o(hour_tick)
  );

  always_comb begin
    tmr_nxt = tmr_r;
    sub_nxt = sub_r;
    thr_nxt = thr_r;
    if (wr_thresh && reg_wdata_i <= `LMM_THRESH_OFF) begin
      thr_nxt = reg_wdata_i; // out-of-range values ignored
    end
    if (wr_timer && reg_wdata_i == 16'h0000) begin
      tmr_nxt = '0; // only a zero write acts
      sub_nxt = '0;
    end else if (hour_tick) begin
      if (sub_r == `LMM_HOURS_PER_UNIT) begin
        sub_nxt = '0;
        if (tmr_r < `LMM_TIMER_MAX) begin
          tmr_nxt = tmr_r + 16'h1;
        end // clamp
      end else begin
        sub_nxt = sub_r + 7'h1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tmr_r <= '0;
      sub_r <= '0;
      thr_r <= `LMM_THRESH_OFF;
      fan_r <= 1'b0;
      nv_save_o <= 1'b0;
    end else begin
      tmr_r <= tmr_nxt;
      sub_r <= sub_nxt;
      thr_r <= thr_nxt;
      fan_r <= fan_nxt;
      nv_save_o <= hour_tick; // hourly save of the total
    end
  end

  assign nv_hours_o = tmr_r;
  assign nv_sub_o = sub_r;
  assign maint_al = thr_r != `LMM_THRESH_OFF && tmr_r >= thr_r;
  assign maint_timer_alarm_out_o = maint_al;
  assign maint_due_indication_o = maint_al;

  lmm_out_select #(
    .N_TERM(N_TERM)
  ) u_terms (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .codes_i(term_codes),
    .life_alarm_i(life_alarm_out_o),
    .maint_alarm_i(maint_al),
    .term_o(terminal_o)
  );

  // ********************************
  // terminal codes, interrupts, read port
  // ********************************
  logic [`LMM_IRQ_W-1:0] irq_st_r, irq_st_nxt, irq_mask_r, irq_mask_nxt, irq_ev;
  logic life_d_r, maint_d_r;
  logic [15:0] rdata_r, rdata_nxt;
  logic [7:0] term_ofs;

  assign irq_ev = {maint_al & ~maint_d_r, life_alarm_out_o & ~life_d_r, meas_end};
  assign term_ofs = reg_addr_i - `LMM_OFS_TERM_BASE;

  // next values; an event in the clearing read's cycle survives
  always_comb begin
    term_codes_nxt = term_codes;
    irq_mask_nxt = irq_mask_r;
    rdata_nxt = '0; // unmapped addresses read zero
    irq_st_nxt = (rd_irq ? '0 : irq_st_r) | irq_ev;
    if (wr_mask) begin
      irq_mask_nxt = reg_wdata_i[`LMM_IRQ_W-1:0];
    end
    for (int i = 0; i < N_TERM; i++) begin
      if (reg_addr_i >= `LMM_OFS_TERM_BASE && term_ofs[1:0] == 2'b00 &&
          32'(term_ofs >> `LMM_TERM_IDX_LSB) == i) begin
        if (reg_wr_i) begin
          term_codes_nxt[8*i +: 8] = reg_wdata_i[7:0];
        end
        rdata_nxt = {8'h00, term_codes[8*i +: 8]};
      end
    end
    unique case (reg_addr_i)
      `LMM_OFS_LIFE_STATUS: rdata_nxt = {12'h000, life_word};
      `LMM_OFS_CAP_PERCENT: rdata_nxt = {8'h00, pct_r};
      `LMM_OFS_MEAS_STATE: rdata_nxt = {12'h000, state_code(st_r)};
      `LMM_OFS_HOURS_TIMER: rdata_nxt = tmr_r;
      `LMM_OFS_ALARM_THRESH: rdata_nxt = thr_r;
      `LMM_OFS_IRQ_STATUS: rdata_nxt = 16'(irq_st_r);
      `LMM_OFS_IRQ_MASK: rdata_nxt = 16'(irq_mask_r);
      default: ;
    endcase
    if (!reg_rd_i) begin
      rdata_nxt = '0;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      term_codes <= '0;
      irq_st_r <= '0;
      irq_mask_r <= '0;
      life_d_r <= 1'b0;
      maint_d_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      term_codes <= term_codes_nxt;
      irq_st_r <= irq_st_nxt;
      irq_mask_r <= irq_mask_nxt;
      life_d_r <= life_alarm_out_o;
      maint_d_r <= maint_al;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign irq_o = |(irq_st_r & irq_mask_r);
endmodule : lmm_top

// *** common/lmm_regs.svh ***
// constants of the life and maintenance monitor: offsets, fields, codes
// assumes a 100 MHz core clock and 16-bit register data
//
// What this block does
// - measured capacitor percent; at or below 85 sets bit1
// - state codes 0,1,2,3,8,9; only 0,1 writable
// - armed state starts 1s stimulus at power loss
// - disturbances end measurement as 8, 9 or stay 1
// - fan at half speed sets bit2 and alarm
// - any single slow fan raises fan condition
// - count energized hours, save hourly, show per 100h
// - partial hours are never counted
// - timer value saturates at 9998
// - alarm when timer reaches threshold; 9999 disables
// - terminal codes 95 active-high, 195 active-low
// - life alarm is OR of four status bits
`ifndef LMM_REGS_SVH
`define LMM_REGS_SVH

// ********************************
// register offsets (byte addresses)
// ********************************
`define LMM_OFS_LIFE_STATUS 8'h00
`define LMM_OFS_CAP_PERCENT 8'h04
`define LMM_OFS_MEAS_STATE 8'h08
`define LMM_OFS_HOURS_TIMER 8'h0C
`define LMM_OFS_ALARM_THRESH 8'h10
`define LMM_OFS_IRQ_STATUS 8'h14
`define LMM_OFS_IRQ_MASK 8'h18
`define LMM_OFS_TERM_BASE 8'h20
`define LMM_TERM_IDX_LSB 2

// ********************************
// fields and values
// ********************************
`define LMM_BIT_CTRL_CAP 0
`define LMM_BIT_MAIN_CAP 1
`define LMM_BIT_FAN 2
`define LMM_BIT_INRUSH 3
`define LMM_IRQ_MEAS_END 0
`define LMM_IRQ_LIFE 1
`define LMM_IRQ_MAINT 2
`define LMM_IRQ_W 3
`define LMM_CAP_FULL 8'h64
`define LMM_CAP_LIMIT 8'h55
`define LMM_TIMER_MAX 16'h270E
`define LMM_THRESH_OFF 16'h270F
`define LMM_HOURS_PER_UNIT 7'h63
`define LMM_ST_IDLE 4'h0
`define LMM_ST_ARMED 4'h1
`define LMM_ST_MEAS 4'h2
`define LMM_ST_DONE 4'h3
`define LMM_ST_FORCED 4'h8
`define LMM_ST_ERROR 4'h9

// ********************************
// terminal function codes
// ********************************
`define LMM_FC_LIFE_POS 8'h5A
`define LMM_FC_LIFE_NEG 8'hBE
`define LMM_FC_MAINT_POS 8'h5F
`define LMM_FC_MAINT_NEG 8'hC3

// ********************************
// timing
// ********************************
`define LMM_CLK_HZ 64'd100000000
`define LMM_STIM_S 64'd1
`define LMM_HOUR_S 64'd3600
`define LMM_STIM_CYCLES (`LMM_STIM_S * `LMM_CLK_HZ)
`define LMM_HOUR_CYCLES (`LMM_HOUR_S * `LMM_CLK_HZ)

`endif

// *** common/lmm_pkg.sv ***
// types shared by the life and maintenance monitor
// assumes lmm_regs.svh supplies the numeric constants
package lmm_pkg;
  // measurement sequencer, one-hot
  typedef enum logic [5:0] {
    LMM_S_IDLE = 6'h01,
    LMM_S_ARMED = 6'h02,
    LMM_S_MEAS = 6'h04,
    LMM_S_DONE = 6'h08,
    LMM_S_FORCED = 6'h10,
    LMM_S_ERROR = 6'h20
  } lmm_meas_t;
endpackage : lmm_pkg

// *** design/lmm_hour_prescaler.sv ***
// hour prescaler for the energized-time counter
// assumes run_i is already synchronous to core_clk_i
`timescale 1ns/100ps
`include "lmm_regs.svh"
module lmm_hour_prescaler
  import lmm_pkg::*;
#(
  parameter logic [39:0] HOUR_CYCLES = 40'(`LMM_HOUR_CYCLES)
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic run_i, // supply present
  output logic tick_o // one-cycle pulse per whole hour
);
  logic [39:0] cnt_r; // cycles into the current hour
  logic [39:0] cnt_nxt;
  logic tick_nxt;
  logic tick_r;

  // ********************************
  // next count
  // ********************************
  always_comb begin
    tick_nxt = 1'b0;
    if (!run_i) begin
      cnt_nxt = '0; // partial hour dropped at power loss
    end else if (cnt_r == HOUR_CYCLES - 40'h1) begin
      cnt_nxt = '0;
      tick_nxt = 1'b1; // only a completed hour ticks
    end else begin
      cnt_nxt = cnt_r + 40'h1;
    end
  end

  // registers
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_o = tick_r;
endmodule : lmm_hour_prescaler

// *** design/lmm_out_select.sv ***
// output terminal function selection for the two alarm signals
// assumes codes come from registers in the same clock domain
`timescale 1ns/100ps
`include "lmm_regs.svh"
module lmm_out_select
  import lmm_pkg::*;
#(
  parameter int N_TERM = 7
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [8*N_TERM-1:0] codes_i, // one 8-bit code per terminal
  input wire logic life_alarm_i,
  input wire logic maint_alarm_i,
  output logic [N_TERM-1:0] term_o
);
  logic [N_TERM-1:0] term_nxt;
  logic [N_TERM-1:0] term_r;

  // map one function code to a level; unknown codes stay low
  function automatic logic term_drive(input logic [7:0] code, input logic life,
                                      input logic maint);
    unique case (code)
      `LMM_FC_LIFE_POS: term_drive = life;
      `LMM_FC_LIFE_NEG: term_drive = ~life;
      `LMM_FC_MAINT_POS: term_drive = maint;
      `LMM_FC_MAINT_NEG: term_drive = ~maint;
      default: term_drive = 1'b0;
    endcase
  endfunction : term_drive

  // ********************************
  // per-terminal decode
  // ********************************
  always_comb begin
    for (int i = 0; i < N_TERM; i++) begin
      term_nxt[i] = term_drive(codes_i[8*i +: 8], life_alarm_i, maint_alarm_i);
    end
  end

  // registered so the terminals never glitch on a code change
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      term_r <= '0;
    end else begin
      term_r <= term_nxt;
    end
  end

  assign term_o = term_r;
endmodule : lmm_out_select

// *** test/lmm_top_assertions.sv ***
// concurrent checks on the monitor's top ports
// assumes one clock domain and the bind below
`timescale 1ns/100ps
module lmm_top_checker #(
  parameter int N_FAN = 2,
  parameter logic [31:0] STIM_CYCLES = 32'h0000_0008
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic inrush_life_i,
  input wire logic [N_FAN-1:0] fan_slow_i,
  input wire logic fan_fault_indication_o,
  input wire logic life_alarm_out_o,
  input wire logic maint_timer_alarm_out_o,
  input wire logic maint_due_indication_o,
  input wire logic dc_stim_o,
  input wire logic nv_save_o,
  input wire logic [15:0] nv_hours_o,
  input wire logic [6:0] nv_sub_o
);
  // ****************
  // helper: length of the current stimulus burst
  // ****************
  logic [31:0] stim_cnt_r; // cycles with stimulus high so far
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stim_cnt_r <= 32'h0000_0000;
    end else begin
      stim_cnt_r <= dc_stim_o ? stim_cnt_r + 32'h0000_0001 : 32'h0000_0000;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  // ****************
  // assertions
  // ****************
  a_stim_len: assert property (stim_cnt_r <= STIM_CYCLES)
    else $error("stimulus held too long");
  a_fan_any: assert property ((|fan_slow_i) [*5] |-> fan_fault_indication_o)
    else $error("slow fan not flagged");
  a_fan_life: assert property (fan_fault_indication_o |-> life_alarm_out_o)
    else $error("fan flag without life alarm");
  a_inrush_life: assert property (inrush_life_i [*5] |-> life_alarm_out_o)
    else $error("inrush wear without life alarm");
  a_timer_clamp: assert property (nv_hours_o <= 16'h270E)
    else $error("timer above ceiling");
  a_hour_step: assert property (($changed(nv_hours_o) && nv_hours_o != 16'h0000)
    |-> nv_hours_o == $past(nv_hours_o) + 16'h0001)
    else $error("timer moved by more than one");
  a_sub_range: assert property (nv_sub_o <= 7'h63)
    else $error("sub-unit count out of range");
  a_save_gap: assert property (nv_save_o |=> (!nv_save_o) [*8])
    else $error("save pulses too close");
  a_maint_pair: assert property (maint_timer_alarm_out_o == maint_due_indication_o)
    else $error("maintenance outputs disagree");
  a_rd_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
    else $error("read data outside read cycle");
endmodule : lmm_top_checker

bind lmm_top lmm_top_checker #(.N_FAN(N_FAN), .STIM_CYCLES(STIM_CYCLES)) u_chk (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .inrush_life_i(inrush_life_i), .fan_slow_i(fan_slow_i),
  .fan_fault_indication_o(fan_fault_indication_o), .life_alarm_out_o(life_alarm_out_o),
  .maint_timer_alarm_out_o(maint_timer_alarm_out_o),
  .maint_due_indication_o(maint_due_indication_o), .dc_stim_o(dc_stim_o),
  .nv_save_o(nv_save_o), .nv_hours_o(nv_hours_o), .nv_sub_o(nv_sub_o));

// *** test/lmm_motor_model.sv ***
// motor and capacitor front end seen by the monitor
// assumes the bench sets what a measurement should read
`timescale 1ns/100ps
module lmm_motor_model (
  input wire logic stim_i,
  input wire logic [7:0] pct_i,
  input wire logic present_i,
  input wire logic coast_i,
  output logic motor_present_o,
  output logic motor_coasting_o,
  output logic [7:0] cap_pct_o
);
  // ****************
  // motor state and reading
  // ****************
  // reading only valid under stimulus; inverted otherwise so stale samples show
  always_comb begin
    motor_present_o = present_i;
    motor_coasting_o = coast_i;
    cap_pct_o = stim_i ? pct_i : ~pct_i;
  end
endmodule : lmm_motor_model

// *** test/tb_top.sv ***
// self-checking bench for the life and maintenance monitor
// assumes short hour and stimulus counts set below
`timescale 1ns/100ps
`include "lmm_regs.svh"
module tb_top;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, sup = 1'b1, start = 1'b0;
  logic astop = 1'b0, inr = 1'b0, m_pres = 1'b1, m_coast = 1'b0, stim, mp, mc;
  logic [7:0] addr = 8'h00, m_pct = 8'h64, cp;
  logic [15:0] wd = 16'h0000, rdata, hrs;
  logic [1:0] fan = 2'h0;
  logic shut = 1'b0, ccap = 1'b0;
  logic [6:0] term, sub;
  logic life, fanf, maint, irq;
  int miscompares = 0, cmp_count = 0, cycles = 0;
  always #5 clk = ~clk;
  lmm_motor_model pm (.stim_i(stim), .pct_i(m_pct), .present_i(m_pres), .coast_i(m_coast),
    .motor_present_o(mp), .motor_coasting_o(mc), .cap_pct_o(cp));
  lmm_top #(.HOUR_CYCLES(40'h14), .STIM_CYCLES(32'h8)) dut (.core_clk_i(clk),
    .reset_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .supply_ok_i(sup), .motor_present_i(mp), .motor_coasting_i(mc),
    .output_shutoff_input_i(shut), .start_cmd_i(start), .alarm_stop_i(astop),
    .meas_error_i(1'b0), .cap_meas_pct_i(cp), .fan_slow_i(fan), .ctrl_cap_life_i(ccap),
    .inrush_life_i(inr), .dc_stim_o(stim), .fan_fault_indication_o(fanf),
    .maint_due_indication_o(), .life_alarm_out_o(life), .maint_timer_alarm_out_o(maint),
    .terminal_o(term), .nv_save_o(), .nv_hours_o(hrs), .nv_sub_o(sub), .irq_o(irq));
  // ****************
  // bus and compare helpers
  // ****************
  task tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tk
  task wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a; wd <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task rreg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata; // data stand only in this cycle
  endtask : rreg
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task rchk(input string nm, input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    rreg(a, d);
    chk(nm, e, d);
  endtask : rchk
  task end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  // hang guard: the whole run needs roughly 4500 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      end_sim;
    end
  end
  // ****************
  // scenarios
  // ****************
  task automatic t_reset;
    logic [15:0] v[4] = '{16'h0002, 16'h0003, 16'h0008, 16'h0009};
    rchk("pct", `LMM_OFS_CAP_PERCENT, 16'h0064);
    rchk("timer", `LMM_OFS_HOURS_TIMER, 16'h0000);
    rchk("thresh", `LMM_OFS_ALARM_THRESH, 16'h270F);
    rchk("unmapped", 8'h3C, 16'h0000);
    foreach (v[i]) begin
      wreg(`LMM_OFS_MEAS_STATE, v[i]);
      rchk("state_ro", `LMM_OFS_MEAS_STATE, 16'h0000);
    end
  endtask : t_reset
  task t_measure(input logic [7:0] pct);
    int n;
    logic [15:0] d;
    m_pct <= pct;
    rreg(`LMM_OFS_IRQ_STATUS, d); // drop stale events
    wreg(`LMM_OFS_MEAS_STATE, 16'h0001);
    rchk("armed", `LMM_OFS_MEAS_STATE, 16'h0001);
    @(posedge clk) sup <= 1'b0;
    for (n = 0; n < 20 && stim !== 1'b1; n++) tk(1);
    for (n = 0; n < 50 && stim === 1'b1; n++) tk(1);
    chk("stim_len", 16'h0008, 16'(n));
    @(posedge clk) sup <= 1'b1;
    tk(4);
    rchk("done", `LMM_OFS_MEAS_STATE, 16'h0003);
    rchk("pct_meas", `LMM_OFS_CAP_PERCENT, {8'h00, pct});
    rreg(`LMM_OFS_LIFE_STATUS, d);
    chk("bit1", {15'h0000, pct <= 8'h55}, {15'h0000, d[1]});
    chk("irq", 16'h0001, {15'h0000, irq});
    rreg(`LMM_OFS_IRQ_STATUS, d);
    chk("irq_end", 16'h0001, {15'h0000, d[0]});
    chk("irq_clr", 16'h0000, {15'h0000, irq});
  endtask : t_measure
  task t_abort;
    wreg(`LMM_OFS_MEAS_STATE, 16'h0001);
    @(posedge clk) sup <= 1'b0;
    tk(6);
    @(posedge clk) start <= 1'b1;
    tk(4);
    rchk("forced", `LMM_OFS_MEAS_STATE, 16'h0008);
    @(posedge clk) begin sup <= 1'b1; start <= 1'b0; m_pres <= 1'b0; end
    wreg(`LMM_OFS_MEAS_STATE, 16'h0001);
    @(posedge clk) sup <= 1'b0;
    tk(6);
    rchk("no_motor", `LMM_OFS_MEAS_STATE, 16'h0009);
    @(posedge clk) begin sup <= 1'b1; m_pres <= 1'b1; astop <= 1'b1; end
    wreg(`LMM_OFS_MEAS_STATE, 16'h0001);
    @(posedge clk) sup <= 1'b0;
    tk(6);
    rchk("stay_armed", `LMM_OFS_MEAS_STATE, 16'h0001);
    @(posedge clk) begin sup <= 1'b1; astop <= 1'b0; end
    tk(4);
    @(posedge clk) sup <= 1'b0;
    tk(6);
    @(posedge clk) shut <= 1'b1;
    tk(4);
    rchk("shut_forced", `LMM_OFS_MEAS_STATE, 16'h0008);
    @(posedge clk) begin sup <= 1'b1; shut <= 1'b0; end
    wreg(`LMM_OFS_MEAS_STATE, 16'h0000);
  endtask : t_abort
  task t_fan;
    @(posedge clk) fan <= 2'h2;
    tk(5);
    chk("fan_ind", 16'h0001, {15'h0000, fanf});
    chk("life_fan", 16'h0001, {15'h0000, life});
    rchk("st_fan", `LMM_OFS_LIFE_STATUS, 16'h0004);
    @(posedge clk) inr <= 1'b1;
    tk(5);
    rchk("st_inr", `LMM_OFS_LIFE_STATUS, 16'h000C);
    @(posedge clk) ccap <= 1'b1;
    tk(5);
    rchk("st_ccap", `LMM_OFS_LIFE_STATUS, 16'h000D);
    @(posedge clk) begin inr <= 1'b0; fan <= 2'h0; ccap <= 1'b0; end
  endtask : t_fan
  task t_hours;
    int n;
    wreg(`LMM_OFS_ALARM_THRESH, 16'h0001);
    wreg(`LMM_OFS_HOURS_TIMER, 16'h0000);
    for (n = 0; n < 2300 && hrs !== 16'h0001; n++) tk(1);
    chk("unit_time", 16'h0001, {15'h0000, n >= 1975});
    rchk("timer1", `LMM_OFS_HOURS_TIMER, 16'h0001);
    chk("maint_on", 16'h0001, {15'h0000, maint});
    wreg(`LMM_OFS_TERM_BASE, 16'h005F);
    wreg(`LMM_OFS_TERM_BASE + 8'h04, 16'h00C3);
    wreg(`LMM_OFS_TERM_BASE + 8'h08, 16'h005A);
    tk(3);
    chk("term", 16'h0005, {13'h0000, term[2:0]});
    wreg(`LMM_OFS_HOURS_TIMER, 16'h0005);
    rchk("timer_ro", `LMM_OFS_HOURS_TIMER, 16'h0001);
    wreg(`LMM_OFS_ALARM_THRESH, 16'h270F);
    tk(3);
    chk("maint_off", 16'h0000, {15'h0000, maint});
    @(posedge clk) sup <= 1'b0; // prescaler held clear, so no stray tick after the clear
    tk(4);
    wreg(`LMM_OFS_HOURS_TIMER, 16'h0000);
    rchk("timer_clr", `LMM_OFS_HOURS_TIMER, 16'h0000);
    repeat (120) begin
      @(posedge clk) sup <= 1'b1;
      tk(12);
      @(posedge clk) sup <= 1'b0;
      tk(5);
    end
    chk("partial", 16'h0000, {9'h000, sub});
  endtask : t_hours
  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    wreg(`LMM_OFS_IRQ_MASK, 16'h0007);
    t_abort;
    t_measure(8'h56);
    chk("life_low", 16'h0000, {15'h0000, life});
    t_fan;
    t_measure(8'h55);
    chk("life_hi", 16'h0001, {15'h0000, life});
    t_hours;
    end_sim;
  end
endmodule : tb_top
